// *** hw/t01cs_top.v ***
/*
 * Timer 0/1 control, mode and counting logic, external interrupt flags,
 * shared prescaler and the clock-select ticks handed to timers 2 and 3.
 * Assumes a single-cycle SFR write strobe and a read strobe answered one
 * clock later; the interrupt, event and oscillator pins are asynchronous to clk and resynchronised here.
 */
// Summary of operation
// - Timer one overflow sets its flag; while timer zero is split its high byte overflow does; software or vectoring clears it.
// - Timer zero overflow sets its flag; software or vectoring clears it.
// - Each run bit enables its timer at one, disables at zero; timer one ignores its bit while timer zero is split.
// - Interrupt one flag set by edge or level; edge mode clears on vectoring.
// - Level mode: interrupt one flag reads one while its input is active.
// - Interrupt zero flag: edge sets, vector clears; level follows input.
// - Type bit zero means level triggered, one means edge triggered.
// - Timer one runs on run bit, and input one when gated; while timer zero is split it runs on its mode alone.
// - Timer zero runs on run bit, and input zero when gated.
// - Timer one counts selected clock, or falling edges of its event pin unless timer zero is split.
// - Timer zero counts selected clock, or falling edges of its event pin.
// - Timer one modes: 13-bit, 16-bit, 8-bit reload, inactive.
// - Timer zero modes: 13-bit, 16-bit, 8-bit reload, two 8-bit counters.
// - Timer one clock select: prescaled at zero, system clock at one.
// - Timer zero clock select: prescaled at zero, system clock at one.
// - Prescale field: divide by 12, 4, 48, or external clock by 8.
// - Divided external clock is synchronised before advancing a timer.
// - Timer two byte clock selects pick system or external-setting clock.
// - Timer three byte clock selects likewise; high bit only when split.
// - Both timers expose readable, writable low and high bytes, reset zero.
// - 13-bit mode wraps from 0x1FFF to zero and sets overflow.
// - Reload mode: low byte overflow reloads from high byte, sets flag.
// - Split mode: high byte counts internal clock under timer one run.
// - Setting a run bit never clears or presets the count.
`timescale 1ns/1ps
`include "t01cs_consts.vh"

module t01cs_top (
  input wire clk,
  input wire rst_n,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire irq_input_zero,
  input wire irq_input_one,
  input wire irq_input_zero_polarity,
  input wire irq_input_one_polarity,
  input wire timer_zero_event_pin,
  input wire timer_one_event_pin,
  input wire ext_osc_clk,
  input wire vector_timer_zero,
  input wire vector_timer_one,
  input wire vector_irq_zero,
  input wire vector_irq_one,
  input wire timer_two_ext_clock_setting,
  input wire timer_two_split,
  input wire timer_three_ext_clock_setting,
  input wire timer_three_split,
  output reg [7:0] sfr_rdata_q,
  output reg timer_zero_irq_q,
  output reg timer_one_irq_q,
  output reg ext_irq_zero_irq_q,
  output reg ext_irq_one_irq_q,
  output reg timer_one_ovf_pulse_q,
  output reg timer_two_low_tick_q,
  output reg timer_two_high_tick_q,
  output reg timer_three_low_tick_q,
  output reg timer_three_high_tick_q
);

  // Sync bit order: irq0, irq1, event0, event1, ext osc
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  reg [4:0] sync3_q;
  reg [7:0] ctrl_q;
  reg [7:0] mode_q;
  reg [7:0] cksel_q;
  // Count bytes of both timers
  reg [7:0] lo0_q;
  reg [7:0] hi0_q;
  reg [7:0] lo1_q;
  reg [7:0] hi1_q;
  // Free-running prescaler counters
  reg [1:0] div4_q;
  reg [3:0] div12_q;
  reg [5:0] div48_q;
  reg [2:0] ext_div_q;
  reg [7:0] ctrl_d;
  reg [7:0] lo0_d;
  reg [7:0] hi0_d;
  reg [7:0] lo1_d;
  reg [7:0] hi1_d;
  reg [16:0] step0;
  reg [16:0] step1;
  reg [8:0] hi0_step;
  reg [7:0] rdata_d;
  reg ovf0;
  reg ovf1;
  reg ovf_hi0;

  // Active level after polarity; polarity is static so it needs no sync
  wire irq0_act = sync2_q[0] ~^ irq_input_zero_polarity;
  wire irq1_act = sync2_q[1] ~^ irq_input_one_polarity;
  wire irq0_prev = sync3_q[0] ~^ irq_input_zero_polarity;
  wire irq1_prev = sync3_q[1] ~^ irq_input_one_polarity;
  // Event pins must hold each level at least one cycle or edges are lost
  wire ev0_fall = sync3_q[2] & ~sync2_q[2];
  wire ev1_fall = sync3_q[3] & ~sync2_q[3];
  // Rising edge of the synced oscillator; it must stay below clk / 2
  wire ext_rise = sync2_q[4] & ~sync3_q[4];
  wire ext8_tick = ext_rise & ({29'h0, ext_div_q} == `T01CS_EXT_DIV - 1);

  // Compared at full width so the divisors need no cast
  wire tick4 = ({30'h0, div4_q} == `T01CS_DIV4 - 1);
  wire tick12 = ({28'h0, div12_q} == `T01CS_DIV12 - 1);
  wire tick48 = ({26'h0, div48_q} == `T01CS_DIV48 - 1);

  wire [1:0] sca = cksel_q[`T01CS_SCA_HI:`T01CS_SCA_LO];
  wire [1:0] m0 = mode_q[`T01CS_M0_HI:`T01CS_M0_LO];
  wire [1:0] m1 = mode_q[`T01CS_M1_HI:`T01CS_M1_LO];
  wire split0 = (m0 == `T01CS_MODE_SPLIT);

  reg presc_tick;
  always @* begin
    case (sca)
      `T01CS_SCA_DIV12: presc_tick = tick12;
      `T01CS_SCA_DIV4: presc_tick = tick4;
      `T01CS_SCA_DIV48: presc_tick = tick48;
      default: presc_tick = ext8_tick;
    endcase
  end

  // Internal clock: system clock when the select bit is set
  wire clk0_tick = cksel_q[`T01CS_CK_ZERO_SYS] | presc_tick;
  wire clk1_tick = cksel_q[`T01CS_CK_ONE_SYS] | presc_tick;
  wire src0 = mode_q[`T01CS_CNT_SEL_ZERO] ? ev0_fall : clk0_tick;
  // Timer one loses its event pin while timer zero is split
  wire src1 = (mode_q[`T01CS_CNT_SEL_ONE] & ~split0) ? ev1_fall : clk1_tick;
  wire run0 = ctrl_q[`T01CS_RUN_ZERO] & (~mode_q[`T01CS_GATE_ZERO] | irq0_act);
  wire run1_norm = ctrl_q[`T01CS_RUN_ONE] & (~mode_q[`T01CS_GATE_ONE] | irq1_act);
  // While timer zero is split, timer one runs on its mode alone
  wire run1 = (split0 ? 1'b1 : run1_norm) & (m1 != `T01CS_MODE_SPLIT);
  wire inc0 = run0 & src0;
  wire inc1 = run1 & src1;
  // Split high byte never counts pin events, only the internal clock
  wire inc_hi0 = split0 & ctrl_q[`T01CS_RUN_ONE] & clk0_tick;

  // One count step for modes 0..2: {overflow, high, low}
  function [16:0] t01cs_step;
    input [1:0] mode;
    input [7:0] th;
    input [7:0] tl;
    reg [5:0] lo5;
    reg [8:0] hi;
    reg [8:0] lo8;
    reg [16:0] full;
    begin
      lo5 = {1'b0, tl[4:0]} + 6'h01;
      hi = {1'b0, th} + 9'h001;
      lo8 = {1'b0, tl} + 9'h001;
      full = {1'b0, th, tl} + 17'h00001;
      case (mode)
        `T01CS_MODE_13BIT: begin
          if (lo5[5])
            t01cs_step = {hi[8], hi[7:0], tl[7:5], 5'h00};
          else
            t01cs_step = {1'b0, th, tl[7:5], lo5[4:0]};
        end
        `T01CS_MODE_16BIT: t01cs_step = full;
        `T01CS_MODE_RELOAD: begin
          if (lo8[8])
            t01cs_step = {1'b1, th, th};
          else
            t01cs_step = {1'b0, th, lo8[7:0]};
        end
        default: t01cs_step = {1'b0, th, tl};
      endcase
    end
  endfunction

  always @* begin
    step0 = t01cs_step(m0, hi0_q, lo0_q);
    step1 = t01cs_step(m1, hi1_q, lo1_q);
    hi0_step = {1'b0, hi0_q} + 9'h001;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    ovf_hi0 = 1'b0;
    // Count bytes; a write to a byte wins over its count step
    lo0_d = lo0_q;
    hi0_d = hi0_q;
    lo1_d = lo1_q;
    hi1_d = hi1_q;
    if (inc0) begin
      if (split0) begin
        lo0_d = lo0_q + 8'h01;
        ovf0 = (lo0_q == 8'hff);
      end else begin
        lo0_d = step0[7:0];
        hi0_d = step0[15:8];
        ovf0 = step0[16];
      end
    end
    if (inc_hi0) begin
      hi0_d = hi0_step[7:0];
      ovf_hi0 = hi0_step[8];
    end
    if (inc1) begin
      lo1_d = step1[7:0];
      hi1_d = step1[15:8];
      ovf1 = step1[16];
    end
    // No byte latching: a 16-bit read may tear while running
    if (sfr_wr && sfr_addr == `T01CS_ADDR_LO0)
      lo0_d = sfr_wdata;
    if (sfr_wr && sfr_addr == `T01CS_ADDR_HI0)
      hi0_d = sfr_wdata;
    if (sfr_wr && sfr_addr == `T01CS_ADDR_LO1)
      lo1_d = sfr_wdata;
    if (sfr_wr && sfr_addr == `T01CS_ADDR_HI1)
      hi1_d = sfr_wdata;
  end

  // Control register: software write, then vector clear, then set wins
  always @* begin
    ctrl_d = ctrl_q;
    if (sfr_wr && sfr_addr == `T01CS_ADDR_CTRL)
      ctrl_d = sfr_wdata;
    if (vector_timer_one)
      ctrl_d[`T01CS_OVF_ONE] = 1'b0;
    if (vector_timer_zero)
      ctrl_d[`T01CS_OVF_ZERO] = 1'b0;
    // Level flags are not cleared by vectoring; they track the pin
    if (vector_irq_one && ctrl_q[`T01CS_EXT_ONE_EDGE])
      ctrl_d[`T01CS_EXT_ONE_FLAG] = 1'b0;
    if (vector_irq_zero && ctrl_q[`T01CS_EXT_ZERO_EDGE])
      ctrl_d[`T01CS_EXT_ZERO_FLAG] = 1'b0;
    // Split timer zero high byte owns the timer one flag
    if (split0 ? ovf_hi0 : ovf1)
      ctrl_d[`T01CS_OVF_ONE] = 1'b1;
    if (ovf0)
      ctrl_d[`T01CS_OVF_ZERO] = 1'b1;
    // Sets come last so an event never loses to a same-cycle clear
    if (ctrl_d[`T01CS_EXT_ONE_EDGE]) begin
      if (irq1_act & ~irq1_prev)
        ctrl_d[`T01CS_EXT_ONE_FLAG] = 1'b1;
    end else begin
      ctrl_d[`T01CS_EXT_ONE_FLAG] = irq1_act;
    end
    if (ctrl_d[`T01CS_EXT_ZERO_EDGE]) begin
      if (irq0_act & ~irq0_prev)
        ctrl_d[`T01CS_EXT_ZERO_FLAG] = 1'b1;
    end else begin
      ctrl_d[`T01CS_EXT_ZERO_FLAG] = irq0_act;
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    case (sfr_addr)
      `T01CS_ADDR_CTRL: rdata_d = ctrl_q;
      `T01CS_ADDR_MODE: rdata_d = mode_q;
      `T01CS_ADDR_LO0: rdata_d = lo0_q;
      `T01CS_ADDR_HI0: rdata_d = hi0_q;
      `T01CS_ADDR_LO1: rdata_d = lo1_q;
      `T01CS_ADDR_HI1: rdata_d = hi1_q;
      `T01CS_ADDR_CKSEL: rdata_d = cksel_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Byte clock for timers 2/3: system clock when its bit is one
  wire t2_alt = timer_two_ext_clock_setting ? ext8_tick : tick12;
  wire t3_alt = timer_three_ext_clock_setting ? ext8_tick : tick12;
  wire t2_low = cksel_q[`T01CS_CK2_LO] | t2_alt;
  wire t3_low = cksel_q[`T01CS_CK3_LO] | t3_alt;
  // Outside split mode the high byte follows the low-byte clock
  wire t2_high = timer_two_split ? (cksel_q[`T01CS_CK2_HI] | t2_alt) : t2_low;
  wire t3_high = timer_three_split ? (cksel_q[`T01CS_CK3_HI] | t3_alt) : t3_low;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      sync3_q <= 5'h00;
      ctrl_q <= `T01CS_CTRL_RESET;
      mode_q <= `T01CS_MODE_RESET;
      cksel_q <= `T01CS_CKSEL_RESET;
      lo0_q <= `T01CS_COUNT_RESET;
      hi0_q <= `T01CS_COUNT_RESET;
      lo1_q <= `T01CS_COUNT_RESET;
      hi1_q <= `T01CS_COUNT_RESET;
      div4_q <= 2'h0;
      div12_q <= 4'h0;
      div48_q <= 6'h00;
      ext_div_q <= 3'h0;
      sfr_rdata_q <= 8'h00;
      timer_zero_irq_q <= 1'b0;
      timer_one_irq_q <= 1'b0;
      ext_irq_zero_irq_q <= 1'b0;
      ext_irq_one_irq_q <= 1'b0;
      timer_one_ovf_pulse_q <= 1'b0;
      timer_two_low_tick_q <= 1'b0;
      timer_two_high_tick_q <= 1'b0;
      timer_three_low_tick_q <= 1'b0;
      timer_three_high_tick_q <= 1'b0;
    end else begin
      sync1_q <= {ext_osc_clk, timer_one_event_pin, timer_zero_event_pin,
                  irq_input_one, irq_input_zero};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      ctrl_q <= ctrl_d;
      if (sfr_wr && sfr_addr == `T01CS_ADDR_MODE)
        mode_q <= sfr_wdata;
      if (sfr_wr && sfr_addr == `T01CS_ADDR_CKSEL)
        cksel_q <= sfr_wdata;
      lo0_q <= lo0_d;
      hi0_q <= hi0_d;
      lo1_q <= lo1_d;
      hi1_q <= hi1_d;
      div4_q <= tick4 ? 2'h0 : div4_q + 2'h1;
      div12_q <= tick12 ? 4'h0 : div12_q + 4'h1;
      div48_q <= tick48 ? 6'h00 : div48_q + 6'h01;
      if (ext_rise)
        ext_div_q <= ext_div_q + 3'h1;
      // Read data holds until the next read strobe
      if (sfr_rd)
        sfr_rdata_q <= rdata_d;
      // Taken from next state so the copies match the register bits
      timer_zero_irq_q <= ctrl_d[`T01CS_OVF_ZERO];
      timer_one_irq_q <= ctrl_d[`T01CS_OVF_ONE];
      ext_irq_zero_irq_q <= ctrl_d[`T01CS_EXT_ZERO_FLAG];
      ext_irq_one_irq_q <= ctrl_d[`T01CS_EXT_ONE_FLAG];
      // Baud and conversion users still see timer one wrap when split
      timer_one_ovf_pulse_q <= ovf1;
      // Ticks lag their source by one cycle, a fixed phase offset only
      timer_two_low_tick_q <= t2_low;
      timer_two_high_tick_q <= t2_high;
      timer_three_low_tick_q <= t3_low;
      timer_three_high_tick_q <= t3_high;
    end
  end

endmodule // t01cs_top

// *** pkg/t01cs_consts.vh ***
/*
 * Constants for the timer 0/1 control and clock-select block: register
 * addresses, field positions, reset values and prescale divisors.
 * Assumes an 8-bit special-function-register bus with byte addresses.
 */
`ifndef T01CS_CONSTS_VH
`define T01CS_CONSTS_VH

`define T01CS_ADDR_CTRL 8'h88
`define T01CS_ADDR_MODE 8'h89
`define T01CS_ADDR_LO0 8'h8a
`define T01CS_ADDR_LO1 8'h8b
`define T01CS_ADDR_HI0 8'h8c
`define T01CS_ADDR_HI1 8'h8d
`define T01CS_ADDR_CKSEL 8'h8e

`define T01CS_CTRL_RESET 8'h00
`define T01CS_MODE_RESET 8'h00
`define T01CS_CKSEL_RESET 8'h00
`define T01CS_COUNT_RESET 8'h00

// Control register fields
`define T01CS_OVF_ONE 7
`define T01CS_RUN_ONE 6
`define T01CS_OVF_ZERO 5
`define T01CS_RUN_ZERO 4
`define T01CS_EXT_ONE_FLAG 3
`define T01CS_EXT_ONE_EDGE 2
`define T01CS_EXT_ZERO_FLAG 1
`define T01CS_EXT_ZERO_EDGE 0

// Mode register fields
`define T01CS_GATE_ONE 7
`define T01CS_CNT_SEL_ONE 6
`define T01CS_M1_HI 5
`define T01CS_M1_LO 4
`define T01CS_GATE_ZERO 3
`define T01CS_CNT_SEL_ZERO 2
`define T01CS_M0_HI 1
`define T01CS_M0_LO 0

// Clock-select fields
`define T01CS_CK3_HI 7
`define T01CS_CK3_LO 6
`define T01CS_CK2_HI 5
`define T01CS_CK2_LO 4
`define T01CS_CK_ONE_SYS 3
`define T01CS_CK_ZERO_SYS 2
`define T01CS_SCA_HI 1
`define T01CS_SCA_LO 0

// Operating modes
`define T01CS_MODE_13BIT 2'h0
`define T01CS_MODE_16BIT 2'h1
`define T01CS_MODE_RELOAD 2'h2
`define T01CS_MODE_SPLIT 2'h3

// Prescale encodings and divisors
`define T01CS_SCA_DIV12 2'h0
`define T01CS_SCA_DIV4 2'h1
`define T01CS_SCA_DIV48 2'h2
`define T01CS_SCA_EXT8 2'h3
`define T01CS_DIV4 4
`define T01CS_DIV12 12
`define T01CS_DIV48 48
`define T01CS_EXT_DIV 8

`endif

// *** tb/t01cs_properties.sv ***
/* Port checker for t01cs_top.
   Assumes it is bound to every instance; keeps shadows of written registers. */
`timescale 1ns/1ps
module t01cs_checker (
  input wire clk,
  input wire rst_n,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire irq_input_zero,
  input wire irq_input_zero_polarity,
  input wire irq_input_one,
  input wire vector_irq_one,
  input wire timer_two_ext_clock_setting,
  input wire timer_three_split,
  input wire [7:0] sfr_rdata_q,
  input wire timer_one_irq_q,
  input wire ext_irq_zero_irq_q,
  input wire ext_irq_one_irq_q,
  input wire timer_one_ovf_pulse_q,
  input wire timer_two_low_tick_q,
  input wire timer_three_high_tick_q
);
  reg [7:0] ctl_q;
  reg [7:0] md_q;
  reg [7:0] ck_q;
  wire act0 = irq_input_zero == irq_input_zero_polarity;
  // Type and select bits change only by writes, so a shadow is exact
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= 8'h00;
      md_q <= 8'h00;
      ck_q <= 8'h00;
    end else if (sfr_wr) begin
      if (sfr_addr == 8'h88) ctl_q <= sfr_wdata;
      if (sfr_addr == 8'h89) md_q <= sfr_wdata;
      if (sfr_addr == 8'h8e) ck_q <= sfr_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata_q))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (sfr_rd && sfr_addr == 8'h8f |=> sfr_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  chk_mode_readback: assert property (sfr_wr && sfr_addr == 8'h89 ##2 sfr_rd && !sfr_wr &&
    sfr_addr == 8'h89 |=> sfr_rdata_q == $past(sfr_wdata, 3))
    else $error("mode readback differs");
  chk_level_follow: assert property ((!ctl_q[0] && !sfr_wr && $stable(act0)) [*6]
    |-> ext_irq_zero_irq_q == act0)
    else $error("level flag does not follow input");
  chk_edge_clear: assert property ($stable(irq_input_one) [*6] ##0
    (vector_irq_one && ctl_q[2] && !sfr_wr) |-> ##2 !ext_irq_one_irq_q)
    else $error("edge flag not cleared by vectoring");
  chk_tick_sys: assert property (ck_q[4] && $past(ck_q[4]) |-> timer_two_low_tick_q)
    else $error("system clock tick not constant");
  chk_tick_div: assert property (!ck_q[4] && !$past(ck_q[4]) && !timer_two_ext_clock_setting
    && !$past(timer_two_ext_clock_setting) && timer_two_low_tick_q |=> !timer_two_low_tick_q [*8])
    else $error("divided tick too frequent");
  chk_t3_high: assert property (timer_three_split && $past(timer_three_split) && ck_q[7]
    && $past(ck_q[7]) |-> timer_three_high_tick_q)
    else $error("split high tick not constant");
  chk_ovf_sets: assert property (timer_one_ovf_pulse_q && md_q[1:0] != 2'h3
    |-> ##[0:1] timer_one_irq_q)
    else $error("overflow did not set flag");
  chk_flag_cause: assert property ($rose(timer_one_irq_q) && !$past(sfr_wr)
    && md_q[1:0] != 2'h3 |-> timer_one_ovf_pulse_q || $past(timer_one_ovf_pulse_q))
    else $error("flag rose without overflow");
endmodule // t01cs_checker
bind t01cs_top t01cs_checker i_t01cs_checker (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .irq_input_zero(irq_input_zero),
  .irq_input_zero_polarity(irq_input_zero_polarity), .irq_input_one(irq_input_one),
  .vector_irq_one(vector_irq_one), .timer_two_ext_clock_setting(timer_two_ext_clock_setting),
  .timer_three_split(timer_three_split), .sfr_rdata_q(sfr_rdata_q),
  .timer_one_irq_q(timer_one_irq_q), .ext_irq_zero_irq_q(ext_irq_zero_irq_q),
  .ext_irq_one_irq_q(ext_irq_one_irq_q), .timer_one_ovf_pulse_q(timer_one_ovf_pulse_q),
  .timer_two_low_tick_q(timer_two_low_tick_q), .timer_three_high_tick_q(timer_three_high_tick_q));

// *** tb/t01cs_core_model.sv ***
/* Core-side model of the special-function-register bus.
   Assumes clk is the system clock; bus changes at its falling edge. */
`timescale 1ns/1ps
module t01cs_core_model (
  input wire clk,
  input wire [7:0] sfr_rdata_q,
  output reg [7:0] sfr_addr,
  output reg sfr_wr,
  output reg sfr_rd,
  output reg [7:0] sfr_wdata
);
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end
  // One strobe per access; data flipped after so stale values never match
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_wdata = ~d;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata_q;
  endtask
endmodule // t01cs_core_model

// *** tb/tb_t01cs_top.sv ***
/* Self-checking bench for t01cs_top driven through the core model.
   Assumes pins change at the falling clock edge. */
`timescale 1ns/1ps
`include "t01cs_consts.vh"
module tb_t01cs_top;
  reg clk, rst_n, i0, i1, p0, p1, e0, e1, osc, v0, v1, vi0, vi1, x2, s2, x3, s3;
  integer num_errors = 0;
  integer checks = 0;
  integer n, s, c, div;
  reg [7:0] k, d;
  wire [7:0] addr, wd, rq;
  wire wrs, rds, tz, to, ez, eo, ov, t2l, t2h, t3l, t3h;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  t01cs_top i_t01cs_top (.clk(clk), .rst_n(rst_n), .sfr_addr(addr), .sfr_wr(wrs), .sfr_rd(rds),
    .sfr_wdata(wd), .irq_input_zero(i0), .irq_input_one(i1), .irq_input_zero_polarity(p0),
    .irq_input_one_polarity(p1), .timer_zero_event_pin(e0), .timer_one_event_pin(e1),
    .ext_osc_clk(osc), .vector_timer_zero(v0), .vector_timer_one(v1), .vector_irq_zero(vi0),
    .vector_irq_one(vi1), .timer_two_ext_clock_setting(x2), .timer_two_split(s2),
    .timer_three_ext_clock_setting(x3), .timer_three_split(s3), .sfr_rdata_q(rq),
    .timer_zero_irq_q(tz), .timer_one_irq_q(to), .ext_irq_zero_irq_q(ez), .ext_irq_one_irq_q(eo),
    .timer_one_ovf_pulse_q(ov), .timer_two_low_tick_q(t2l), .timer_two_high_tick_q(t2h),
    .timer_three_low_tick_q(t3l), .timer_three_high_tick_q(t3h));
  t01cs_core_model i_t01cs_core_model (.clk(clk), .sfr_rdata_q(rq), .sfr_addr(addr),
    .sfr_wr(wrs), .sfr_rd(rds), .sfr_wdata(wd));
  task end_of_test;
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input string nm, input [7:0] got, input [7:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %s expected %h got %h", nm, exp, got);
    end
  endtask
  function [7:0] near(input integer a, input integer b);
    near = {7'h00, a >= b - 1 && a <= b + 1};
  endfunction
  task wr(input [7:0] a, input [7:0] v);
    i_t01cs_core_model.wr(a, v);
  endtask
  task rdc(input string nm, input [7:0] a, input [7:0] exp);
    i_t01cs_core_model.rd(a, d);
    chk(nm, d, exp);
  endtask
  task cyc(input integer m);
    repeat (m) @(negedge clk);
  endtask
  // Bounded wait on an overflow flag; running out ends the run
  task wt(input sel);
    for (c = 0; (sel ? to : tz) !== 1'b1; c = c + 1) begin
      if (c > 300) begin
        num_errors = num_errors + 1;
        end_of_test;
      end
      cyc(1);
    end
  endtask
  initial begin
    {rst_n, i0, i1, e0, e1, osc, v0, v1, vi0, vi1, x2, s2, x3, s3} = 14'h0000;
    {p0, p1} = 2'h3;
    cyc(20);
    rst_n = 1'b1;
    for (k = 8'h88; k < 8'h90; k = k + 8'h01) rdc("reset", k, 8'h00);
    wr(8'h8f, 8'hff);
    rdc("unmapped", 8'h8f, 8'h00);
    for (k = 8'h89; k < 8'h8e; k = k + 8'h01) begin
      wr(k, k ^ 8'h3c);
      rdc("rw", k, k ^ 8'h3c);
    end
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'hff);
    wr(8'h8e, 8'h04);
    wr(8'h89, 8'h01);
    wr(8'h88, 8'h10);
    wt(0);
    wr(8'h88, 8'h20);
    rdc("wrap16", 8'h8c, 8'h00);
    v0 = 1'b1;
    cyc(1);
    v0 = 1'b0;
    rdc("t0 vector clear", 8'h88, 8'h00);
    wr(8'h8b, 8'h1f);
    wr(8'h8d, 8'hff);
    wr(8'h89, 8'h00);
    wr(8'h8e, 8'h08);
    wr(8'h88, 8'h40);
    wt(1);
    wr(8'h88, 8'h80);
    rdc("wrap13", 8'h8d, 8'h00);
    v1 = 1'b1;
    cyc(1);
    v1 = 1'b0;
    rdc("t1 vector clear", 8'h88, 8'h00);
    wr(8'h8c, 8'ha5);
    wr(8'h8a, 8'hff);
    wr(8'h89, 8'h02);
    wr(8'h8e, 8'h04);
    wr(8'h88, 8'h10);
    wt(0);
    wr(8'h88, 8'h00);
    rdc("reload value", 8'h8c, 8'ha5);
    rdc("reload flag", 8'h88, 8'h00);
    for (k = 8'h8a; k < 8'h8e; k = k + 8'h01) wr(k, 8'h00);
    wr(8'h8e, 8'h0c);
    wr(8'h89, 8'h99);
    wr(8'h88, 8'h50);
    cyc(20);
    rdc("gated", 8'h8a, 8'h00);
    {i0, i1} = 2'h3;
    cyc(20);
    rdc("level flags", 8'h88, 8'h5a);
    {i0, i1} = 2'h0;
    cyc(6);
    wr(8'h88, 8'h00);
    i_t01cs_core_model.rd(8'h8a, d);
    chk("gate run", near(d, 22), 8'h01);
    rdc("gate run one", 8'h8b, d);
    p0 = 1'b0;
    cyc(6);
    rdc("low active", 8'h88, 8'h02);
    chk("level copy", {7'h00, ez}, 8'h01);
    p0 = 1'b1;
    wr(8'h88, 8'h04);
    i1 = 1'b1;
    cyc(6);
    chk("edge flag", {7'h00, eo}, 8'h01);
    vi1 = 1'b1;
    cyc(1);
    vi1 = 1'b0;
    rdc("edge clear", 8'h88, 8'h04);
    i1 = 1'b0;
    for (k = 8'h8a; k < 8'h8e; k = k + 8'h01) wr(k, 8'h00);
    wr(8'h89, 8'h55);
    wr(8'h88, 8'h50);
    repeat (3) begin
      {e0, e1} = 2'h3;
      cyc(4);
      {e0, e1} = 2'h0;
      cyc(4);
    end
    cyc(4);
    wr(8'h88, 8'h00);
    rdc("events zero", 8'h8a, 8'h03);
    rdc("events one", 8'h8b, 8'h03);
    wr(8'h89, 8'h01);
    for (s = 0; s < 4; s = s + 1) begin
      div = s == 0 ? `T01CS_DIV12 : s == 1 ? `T01CS_DIV4 : s == 2 ? `T01CS_DIV48 : `T01CS_EXT_DIV;
      x2 = s == 3;
      wr(8'h8a, 8'h00);
      wr(8'h8e, s[7:0]);
      wr(8'h88, 8'h10);
      n = 0;
      for (c = 0; c < 96; c = c + 1) begin
        cyc(1);
        n = n + t2l;
        if (c[0]) osc = ~osc;
      end
      wr(8'h88, 8'h00);
      i_t01cs_core_model.rd(8'h8a, d);
      chk("prescale", near(d, s == 3 ? 96 / (4 * div) : 96 / div), 8'h01);
      chk("t2 divided tick", near(n, s == 3 ? 3 : 8), 8'h01);
    end
    s3 = 1'b1;
    wr(8'h8e, 8'hd0);
    cyc(3);
    chk("t2 system tick", {7'h00, t2l}, 8'h01);
    chk("t3 high tick", {7'h00, t3h}, 8'h01);
    chk("t2 high follows", {7'h00, t2h}, 8'h01);
    chk("t3 low tick", {7'h00, t3l}, 8'h01);
    wr(8'h8a, 8'h00);
    wr(8'h8c, 8'hfe);
    wr(8'h89, 8'h03);
    wr(8'h8e, 8'h04);
    wr(8'h88, 8'h40);
    wt(1);
    rdc("split low idle", 8'h8a, 8'h00);
    end_of_test;
  end
endmodule // tb_t01cs_top
